//--- logic/tmrpsc_map.vh
`ifndef TMRPSC_MAP_VH
`define TMRPSC_MAP_VH

// ----------
// register indices (byte address is four times the index)
// ----------
`define TMRPSC_IDX_SPECIAL_FUNCTION 6'h2c
`define TMRPSC_IDX_TIMER1_CONTROL 6'h30
`define TMRPSC_IDX_TIMER0_COUNT 6'h32
`define TMRPSC_IDX_TIMER0_CONTROL 6'h33
`define TMRPSC_IDX_FLAG 6'h38
`define TMRPSC_IDX_MASK 6'h39

// ----------
// field positions
// ----------
`define TMRPSC_SF_TIMER0_PRESCALER_CLEAR_BIT 0
`define TMRPSC_SF_TIMER1_PRESCALER_CLEAR_BIT 1
`define TMRPSC_SF_FORCE_BIT 2
`define TMRPSC_T1_CLEAR_ON_MATCH_BIT 7
`define TMRPSC_T1_PWM_BIT 6
`define TMRPSC_T1_COM_HI 5
`define TMRPSC_T1_COM_LO 4
`define TMRPSC_T1_CS_HI 3
`define TMRPSC_FLAG_T0_OVF_BIT 0

// ----------
// reset values
// ----------
`define TMRPSC_RST_TIMER0_CONTROL 3'h0
`define TMRPSC_RST_TIMER1_CONTROL 8'h00
`define TMRPSC_RST_COUNT 8'h00
`define TMRPSC_RST_MASK 1'h0

// ----------
// timing: fast timebase is clk, core timebase is clk divided by 16
// ----------
`define TMRPSC_CLK_MHZ 40
`define TMRPSC_FAST_MULT 16
`define TMRPSC_CORE_DIV_LAST 4'hf
`define TMRPSC_PSC_BITS 10

// ----------
// bus answers
// ----------
`define TMRPSC_RESP_OKAY 2'h0
`define TMRPSC_RESP_SLVERR 2'h2

`endif

//--- logic/tmrpsc_prescaler.v
`timescale 1ns/100ps

// 10-bit prescaler: counts enable pulses, gives one-cycle taps
module tmrpsc_prescaler (
    // clock and reset
    input wire clk,
    input wire rstn,
    // control
    input wire step,        // advance one count
    input wire clear,       // synchronous prescaler reset
    // taps: tap[k] is step divided by 2**k
    output wire [10:0] tap
);

    reg [9:0] count; // prescaler state

    // ----------
    // counter
    // ----------
    // clear beats step so software gets a predictable phase
    always @(posedge clk) begin
        if (!rstn) begin
            count <= 10'h000;
        end else if (clear) begin
            count <= 10'h000;
        end else if (step) begin
            count <= count + 10'h001;
        end
    end

    // ----------
    // taps: fire when all lower bits are one and a step arrives
    // ----------
    assign tap[0] = step & ~clear;
    genvar k;
    generate
        for (k = 1; k <= 10; k = k + 1) begin : g_tap
            assign tap[k] = step & ~clear & (&count[k-1:0]);
        end
    endgenerate

endmodule // tmrpsc_prescaler

//--- logic/tmrpsc_top.v
// Behaviour
// - fast timebase is sixteen times core timebase
// - timer1 prescaler offers sixteen clock selections
// - prescaler-one clear bit resets, self-clears, reads zero
// - prescaler-zero clear bit resets, self-clears, reads zero
// - force applies compare action, no interrupt/clear
// - force reads zero, ignored in pwm mode
// - special register upper five bits read zero
// - count input sampled on clock before edges
// - timer0 three-bit source select decode
// - timer0 control upper bits zero, select resets
// - count input counts even when pin outputs
// - timer0 writable counter resumes on next tick
// - two independent ten-bit prescalers
// - overflow flag gated by mask bit
// - compare action encoding off/toggle/clear/set
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "tmrpsc_map.vh"

module tmrpsc_top (
    // clock and reset (clk is the fast peripheral timebase)
    input wire clk,
    input wire rstn,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // external count input pin (asynchronous)
    input wire count_input_pin,
    // timer1 datapath side
    input wire timer1_compare_match,   // one-cycle match pulse
    output reg timer1_count_tick,      // selected timer1 clock enable
    output reg compare_output_pin,     // compare output level
    // interrupt
    output wire irq
);

    // ----------
    // registers and state
    // ----------
    reg [3:0] core_div;          // divides clk down to core timebase
    reg core_tick;               // one-cycle core timebase enable
    reg [2:0] fast_div;          // fast-side part of timer1 prescaler
    reg [2:0] timer0_source;     // timer0_source_bit2..0
    reg [7:0] timer1_control;    // clear_on_match, pwm, compare action, select
    reg [7:0] timer0_count_value; // timer0 counter
    reg ovf_flag;                // sticky timer0 overflow
    reg ovf_mask;                // overflow interrupt enable
    reg pin_meta;                // first synchroniser stage
    reg pin_sync;                // second synchroniser stage
    reg pin_prev;                // previous synchronised level
    reg timer0_prescaler_clear;  // one-cycle pulse
    reg timer1_prescaler_clear;  // one-cycle pulse
    reg force_compare_output;    // one-cycle pulse
    reg timer0_tick;             // selected timer0 clock enable

    wire [10:0] tap0;            // timer0 prescaler taps
    wire [10:0] tap1;            // timer1 prescaler taps

    // ----------
    // bus slave state
    // ----------
    reg aw_held;                 // write address captured
    reg w_held;                  // write data captured
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire [5:0] wr_index;
    wire [5:0] rd_index;
    wire do_write;
    wire do_read;
    wire wr_lane0;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign do_read = s_axi_arvalid & ~s_axi_rvalid;
    assign wr_index = aw_addr[7:2];
    assign rd_index = s_axi_araddr[7:2];
    assign wr_lane0 = do_write & w_strb[0];

    // ----------
    // write channel capture, in either order
    // ----------
    always @(posedge clk) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // ----------
    // write response; unmapped index answers slverr
    // ----------
    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMRPSC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            case (wr_index)
                `TMRPSC_IDX_SPECIAL_FUNCTION,
                `TMRPSC_IDX_TIMER1_CONTROL,
                `TMRPSC_IDX_TIMER0_COUNT,
                `TMRPSC_IDX_TIMER0_CONTROL,
                `TMRPSC_IDX_FLAG,
                `TMRPSC_IDX_MASK: s_axi_bresp <= `TMRPSC_RESP_OKAY;
                default: s_axi_bresp <= `TMRPSC_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------
    // control registers
    // ----------
    always @(posedge clk) begin
        if (!rstn) begin
            timer0_source <= `TMRPSC_RST_TIMER0_CONTROL;
            timer1_control <= `TMRPSC_RST_TIMER1_CONTROL;
            ovf_mask <= `TMRPSC_RST_MASK;
        end else if (wr_lane0) begin
            case (wr_index)
                `TMRPSC_IDX_TIMER0_CONTROL: timer0_source <= w_data[2:0];
                `TMRPSC_IDX_TIMER1_CONTROL: timer1_control <= w_data[7:0];
                `TMRPSC_IDX_MASK: ovf_mask <= w_data[`TMRPSC_FLAG_T0_OVF_BIT];
                default: ;
            endcase
        end
    end

    // ----------
    // self-clearing strobes: only a written one acts
    // ----------
    always @(posedge clk) begin
        if (!rstn) begin
            timer0_prescaler_clear <= 1'b0;
            timer1_prescaler_clear <= 1'b0;
            force_compare_output <= 1'b0;
        end else begin
            // the bit lives one cycle, so hardware has cleared it after use
            timer0_prescaler_clear <= wr_lane0 &&
                (wr_index == `TMRPSC_IDX_SPECIAL_FUNCTION) &&
                w_data[`TMRPSC_SF_TIMER0_PRESCALER_CLEAR_BIT];
            timer1_prescaler_clear <= wr_lane0 &&
                (wr_index == `TMRPSC_IDX_SPECIAL_FUNCTION) &&
                w_data[`TMRPSC_SF_TIMER1_PRESCALER_CLEAR_BIT];
            force_compare_output <= wr_lane0 &&
                (wr_index == `TMRPSC_IDX_SPECIAL_FUNCTION) &&
                w_data[`TMRPSC_SF_FORCE_BIT];
        end
    end

    // ------------------------------------------------------------
    // core timebase: clk is the 16x fast timebase, so any trim of
    // the source clock scales both rates together
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            core_div <= 4'h0;
            core_tick <= 1'b0;
        end else begin
            core_div <= core_div + 4'h1;
            core_tick <= (core_div == `TMRPSC_CORE_DIV_LAST);
        end
    end

    // ------------------------------------------------------------
    // fast part of timer1 prescaler, cleared with the slow part
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            fast_div <= 3'h0;
        end else if (timer1_prescaler_clear) begin
            fast_div <= 3'h0;
        end else begin
            fast_div <= fast_div + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // two independent prescalers on the core timebase
    // ------------------------------------------------------------
    tmrpsc_prescaler u_psc0 (
        .clk(clk),
        .rstn(rstn),
        .step(core_tick),
        .clear(timer0_prescaler_clear),
        .tap(tap0)
    );

    tmrpsc_prescaler u_psc1 (
        .clk(clk),
        .rstn(rstn),
        .step(core_tick),
        .clear(timer1_prescaler_clear),
        .tap(tap1)
    );

    // ------------------------------------------------------------
    // count input synchroniser and edge detect
    // ------------------------------------------------------------
    // read regardless of pin direction, so software can drive counts
    always @(posedge clk) begin
        if (!rstn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= count_input_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // ----------
    // timer0 source select
    // ----------
    // edges shorter than a clock period are lost; the source must space them
    always @* begin
        case (timer0_source)
            3'h0: timer0_tick = 1'b0;
            3'h1: timer0_tick = tap0[0];
            3'h2: timer0_tick = tap0[3];
            3'h3: timer0_tick = tap0[6];
            3'h4: timer0_tick = tap0[8];
            3'h5: timer0_tick = tap0[10];
            3'h6: timer0_tick = pin_prev & ~pin_sync;
            3'h7: timer0_tick = ~pin_prev & pin_sync;
            default: timer0_tick = 1'b0;
        endcase
    end

    // ----------
    // timer1 source select
    // ----------
    always @* begin
        case (timer1_control[`TMRPSC_T1_CS_HI:0])
            4'h0: timer1_count_tick = 1'b0;
            4'h1: timer1_count_tick = 1'b1;
            4'h2: timer1_count_tick = fast_div[0];
            4'h3: timer1_count_tick = &fast_div[1:0];
            4'h4: timer1_count_tick = &fast_div[2:0];
            4'h5: timer1_count_tick = tap1[0];
            4'h6: timer1_count_tick = tap1[1];
            4'h7: timer1_count_tick = tap1[2];
            4'h8: timer1_count_tick = tap1[3];
            4'h9: timer1_count_tick = tap1[4];
            4'ha: timer1_count_tick = tap1[5];
            4'hb: timer1_count_tick = tap1[6];
            4'hc: timer1_count_tick = tap1[7];
            4'hd: timer1_count_tick = tap1[8];
            4'he: timer1_count_tick = tap1[9];
            4'hf: timer1_count_tick = tap1[10];
            default: timer1_count_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // timer0 counter; a write wins over a tick in the same cycle
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            timer0_count_value <= `TMRPSC_RST_COUNT;
        end else if (wr_lane0 && (wr_index == `TMRPSC_IDX_TIMER0_COUNT)) begin
            timer0_count_value <= w_data[7:0];
        end else if (timer0_tick) begin
            timer0_count_value <= timer0_count_value + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // overflow flag: set on wrap, cleared by read or write-one;
    // set wins over either clear
    // ------------------------------------------------------------
    wire ovf_set;
    wire ovf_clr;
    assign ovf_set = timer0_tick & (timer0_count_value == 8'hff) &
        ~(wr_lane0 && (wr_index == `TMRPSC_IDX_TIMER0_COUNT));
    assign ovf_clr = (do_read && (rd_index == `TMRPSC_IDX_FLAG)) ||
        (wr_lane0 && (wr_index == `TMRPSC_IDX_FLAG) &&
         w_data[`TMRPSC_FLAG_T0_OVF_BIT]);

    always @(posedge clk) begin
        if (!rstn) begin
            ovf_flag <= 1'b0;
        end else if (ovf_set) begin
            ovf_flag <= 1'b1;
        end else if (ovf_clr) begin
            ovf_flag <= 1'b0;
        end
    end

    assign irq = ovf_flag & ovf_mask;

    // ------------------------------------------------------------
    // compare output pin: real match or forced, same action table
    // ------------------------------------------------------------
    // force raises no flag and touches no counter; only the pin moves
    wire compare_event;
    assign compare_event = ~timer1_control[`TMRPSC_T1_PWM_BIT] &
        (timer1_compare_match | force_compare_output);

    always @(posedge clk) begin
        if (!rstn) begin
            compare_output_pin <= 1'b0;
        end else if (compare_event) begin
            case (timer1_control[`TMRPSC_T1_COM_HI:`TMRPSC_T1_COM_LO])
                2'h0: compare_output_pin <= compare_output_pin;
                2'h1: compare_output_pin <= ~compare_output_pin;
                2'h2: compare_output_pin <= 1'b0;
                2'h3: compare_output_pin <= 1'b1;
                default: compare_output_pin <= compare_output_pin;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read channel: one cycle latency, unmapped answers slverr
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TMRPSC_RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `TMRPSC_RESP_OKAY;
            case (rd_index)
                // strobes and reserved bits always read zero
                `TMRPSC_IDX_SPECIAL_FUNCTION: s_axi_rdata <= 32'h00000000;
                `TMRPSC_IDX_TIMER1_CONTROL: s_axi_rdata <= {24'h000000, timer1_control};
                `TMRPSC_IDX_TIMER0_COUNT: s_axi_rdata <= {24'h000000, timer0_count_value};
                `TMRPSC_IDX_TIMER0_CONTROL: s_axi_rdata <= {29'h00000000, timer0_source};
                `TMRPSC_IDX_FLAG: s_axi_rdata <= {31'h00000000, ovf_flag};
                `TMRPSC_IDX_MASK: s_axi_rdata <= {31'h00000000, ovf_mask};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `TMRPSC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // tmrpsc_top

//--- test/tmrpsc_monitor.sv
`timescale 1ns/100ps

// ----------
// port checker for the timer block
// ----------
module tmrpsc_monitor (
    // clock and reset
    input wire clk,
    input wire rstn,
    // register bus
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    // timer side
    input wire timer1_count_tick,
    input wire compare_output_pin,
    input wire irq
);
    reg [7:0] t1c; // shadow of timer1 control
    reg m; // shadow of mask bit
    reg [7:0] ra; // address of read under way
    wire [3:0] sel = t1c[3:0];
    // shadows assume address and data taken together
    wire wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire frc = wt && s_axi_awaddr == 8'hb0 && s_axi_wdata[2];

    // shadow registers, updated on handshakes
    always @(posedge clk) begin
        if (!rstn) begin
            t1c <= 8'h00;
            m <= 1'b0;
            ra <= 8'h00;
        end else begin
            if (wt && s_axi_awaddr == 8'hc0) t1c <= s_axi_wdata[7:0];
            if (wt && s_axi_awaddr == 8'he4) m <= s_axi_wdata[0];
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    stop_no_tick_a: assert property (sel == 4'h0 && $past(sel, 2) == 4'h0
        |-> !timer1_count_tick) else $error("tick while stopped");
    fast_tick_a: assert property (sel == 4'h1 && $past(sel, 2) == 4'h1
        |-> timer1_count_tick) else $error("fast tick missing");
    half_rate_a: assert property (sel == 4'h2 && $past(sel, 2) == 4'h2
        && timer1_count_tick |=> !timer1_count_tick) else $error("half rate wrong");
    core_period_a: assert property (sel == 4'h5 && timer1_count_tick
        |=> !timer1_count_tick [*8] ##8 (timer1_count_tick || sel != 4'h5))
        else $error("core period wrong");
    special_zero_a: assert property (s_axi_rvalid && ra == 8'hb0
        |-> s_axi_rdata == 32'h0) else $error("special reads nonzero");
    ctl_upper_a: assert property (s_axi_rvalid && ra == 8'hcc
        |-> s_axi_rdata[31:3] == 29'h0) else $error("control upper bits set");
    force_set_a: assert property (frc && t1c[6:4] == 3'h3
        |-> ##[1:4] compare_output_pin) else $error("force set failed");
    force_clear_a: assert property (frc && t1c[6:4] == 3'h2
        |-> ##[1:4] !compare_output_pin) else $error("force clear failed");
    pwm_ignore_a: assert property (frc && t1c[6]
        |=> $stable(compare_output_pin) [*5]) else $error("force acted in pwm");
    masked_quiet_a: assert property (!m && !$past(m, 3) |-> !irq)
        else $error("irq while masked");
endmodule // tmrpsc_monitor

bind tmrpsc_top tmrpsc_monitor u_mon (.clk(clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .irq(irq),
    .timer1_count_tick(timer1_count_tick), .compare_output_pin(compare_output_pin));

//--- test/tmrpsc_count_source.sv
`timescale 1ns/100ps

// ----------
// external event source on the count input
// ----------
module tmrpsc_count_source (
    // clock
    input wire clk,
    // pin, idle low
    output reg count_input_pin
);
    initial count_input_pin = 1'b0;

    // n pulses, changes off the clock edge like a real async source
    task emit(input integer n);
        integer i;
        begin
            for (i = 0; i < 2 * n; i = i + 1) begin
                repeat (20) @(posedge clk); // longer than a core period
                #7 count_input_pin = ~count_input_pin; // pin may be an output
            end
        end
    endtask
endmodule // tmrpsc_count_source

//--- test/tb_tmrpsc_top.sv
`timescale 1ns/100ps

module tb_tmrpsc_top;
    // ----------
    // nets and counters
    // ----------
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg [7:0] awa = 8'h00; // write address
    reg awv = 1'b0;
    reg [31:0] wd = 32'h0;
    reg [3:0] ws = 4'hf; // byte strobes
    reg wv = 1'b0;
    reg br = 1'b0;
    reg [7:0] ara = 8'h00;
    reg arv = 1'b0;
    reg rr = 1'b0;
    reg match = 1'b0; // timer1 compare pulse
    wire awr, wrdy, bv, arr, rv, tick, pin, irq, cin;
    wire [1:0] bresp, rresp;
    wire [31:0] rdat;
    integer errors = 0;
    integer checks = 0;
    integer ticks = 0; // timer1 enables seen
    reg [31:0] v; // last read data
    reg [1:0] rs; // last read or write answer

    tmrpsc_top uut (.clk(clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .count_input_pin(cin), .timer1_compare_match(match),
        .timer1_count_tick(tick), .compare_output_pin(pin), .irq(irq));
    tmrpsc_count_source src (.clk(clk), .count_input_pin(cin));

    initial forever #12.5 clk = ~clk; // fixed rate, never trimmed up
    always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;

    // ----------
    // shared tasks
    // ----------
    task finish_test;
        begin
            if (errors == 0 && checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    task fail_out; // a wait ran out
        begin
            errors = errors + 1;
            finish_test;
        end
    endtask

    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // handshakes sampled mid-cycle, released after the edge
    task wr(input [7:0] a, input [31:0] d);
        integer n;
        reg ta, tw, ok;
        begin
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            br <= 1'b1;
            ok = 1'b0;
            for (n = 0; n < 40 && !ok; n = n + 1) begin
                @(negedge clk);
                ta = awv && awr === 1'b1;
                tw = wv && wrdy === 1'b1;
                ok = bv === 1'b1;
                rs = bresp;
                @(posedge clk);
                if (ta) awv <= 1'b0;
                if (tw) wv <= 1'b0;
            end
            br <= 1'b0;
            @(posedge clk);
            if (!ok) fail_out;
        end
    endtask

    task rd(input [7:0] a);
        integer n;
        reg t, ok;
        begin
            ara <= a;
            arv <= 1'b1;
            rr <= 1'b1;
            ok = 1'b0;
            for (n = 0; n < 40 && !ok; n = n + 1) begin
                @(negedge clk);
                t = arv && arr === 1'b1;
                ok = rv === 1'b1;
                v = rdat;
                rs = rresp;
                @(posedge clk);
                if (t) arv <= 1'b0;
            end
            rr <= 1'b0;
            @(posedge clk);
            if (!ok) fail_out;
        end
    endtask

    // ----------
    // scenarios
    // ----------
    task t_regs;
        begin
            rd(8'hcc);
            chk("timer0 control", v, 32'h0);
            rd(8'hc8);
            chk("timer0 count", v, 32'h0);
            wr(8'hcc, 32'hff);
            rd(8'hcc);
            chk("timer0 control", v, 32'h7);
            ws <= 4'h0; // strobe off: no change
            wr(8'hcc, 32'h0);
            ws <= 4'hf;
            rd(8'hcc);
            chk("timer0 control", v, 32'h7);
            wr(8'hcc, 32'h0);
            wr(8'hb0, 32'hf8);
            rd(8'hb0);
            chk("special", v, 32'h0);
            rd(8'h00);
            chk("unmapped answer", {30'h0, rs}, 32'h2);
            wr(8'h00, 32'h0);
            chk("unmapped write", {30'h0, rs}, 32'h2);
        end
    endtask

    task t_force; // action order set, off, clear, toggle
        integer k;
        reg [7:0] ord;
        reg [3:0] exp;
        begin
            ord = 8'h63;
            exp = 4'hb;
            for (k = 0; k < 4; k = k + 1) begin
                wr(8'hc0, {26'h0, ord[2*k+:2], 4'h0});
                wr(8'hb0, 32'h4);
                repeat (3) @(posedge clk);
                chk("compare pin", pin, exp[k]);
            end
            wr(8'hc0, 32'h60); // pwm with clear action
            wr(8'hb0, 32'h4);
            repeat (3) @(posedge clk);
            chk("compare pin", pin, 32'h1);
            wr(8'hc0, 32'h20);
            match <= 1'b1;
            @(posedge clk);
            match <= 1'b0;
            repeat (3) @(posedge clk);
            chk("compare pin", pin, 32'h0);
            chk("irq", irq, 32'h0);
        end
    endtask

    // window is a multiple of each period, so counts are exact
    task t_ticks;
        integer s, t0;
        begin
            for (s = 0; s < 13; s = s + 1) begin
                wr(8'hc0, s);
                t0 = ticks;
                repeat (4096) @(posedge clk);
                chk("timer1 ticks", ticks - t0, s == 0 ? 0 : 4096 >> (s - 1));
            end
        end
    endtask

    // resets closer than either selected tap period: no tick may escape
    task t_psc;
        integer t0;
        begin
            wr(8'hc0, 32'h9);
            wr(8'hcc, 32'h3);
            wr(8'hb0, 32'h3);
            wr(8'hc8, 32'h0);
            t0 = ticks;
            repeat (12) begin
                repeat (200) @(posedge clk);
                wr(8'hb0, 32'h3);
            end
            chk("timer1 ticks", ticks - t0, 0);
            rd(8'hc8);
            chk("timer0 count", v, 32'h0);
            wr(8'hcc, 32'h0);
        end
    endtask

    task t_ext;
        begin
            wr(8'hc8, 32'h40);
            wr(8'hcc, 32'h7);
            src.emit(5);
            repeat (10) @(posedge clk);
            rd(8'hc8);
            chk("timer0 count", v, 32'h45);
            wr(8'hcc, 32'h6);
            src.emit(3);
            repeat (10) @(posedge clk);
            rd(8'hc8);
            chk("timer0 count", v, 32'h48);
            wr(8'hcc, 32'h0);
        end
    endtask

    task t_ovf;
        begin
            wr(8'he4, 32'h0);
            wr(8'hc8, 32'hfe);
            wr(8'hcc, 32'h1);
            repeat (64) @(posedge clk);
            chk("irq", irq, 32'h0);
            wr(8'he4, 32'h1);
            chk("irq", irq, 32'h1);
            wr(8'hcc, 32'h0);
            rd(8'he0);
            chk("flag", v, 32'h1);
            chk("irq", irq, 32'h0);
            rd(8'he0);
            chk("flag", v, 32'h0);
        end
    endtask

    // ----------
    // main sequence
    // ----------
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs;
        t_force;
        t_ticks;
        t_psc;
        t_ext;
        t_ovf;
        finish_test;
    end
endmodule // tb_tmrpsc_top
